// ===== src/decode_pkg.sv
/*
 * constants, types and register map of the instruction decoder
 * assumes a single clock domain and word-aligned register access
 */
// Summary of operation
// RULE_01: 1011 skips next when selected bit clear, 1010 when set; bits 11:9, bit 8.
// RULE_02: 1110 0ccc branches on flag code with signed 8-bit offset; 1 or 2 cycles.
// RULE_03: 1101 relative jump (bit 11 low) or relative call, 11-bit offset, 2 cycles.
// RULE_04: 1110 110s plus 1111 word gives 20-bit call, s fast context, 2 cycles.
// RULE_05: 1110 1111 plus 1111 word gives 20-bit absolute jump, 2 cycles.
// RULE_06: word 0004 clears watchdog in one cycle, updating timeout and powerdown.
// RULE_07: word 0006 discards stack top, 0005 pushes; no flags change.
// RULE_08: word 00ff is a one-cycle full software reset of all status.
// RULE_09: 0010/0011 return from interrupt, 2 cycles, re-enables both irq enables.
// RULE_10: 0012/0013 return from subroutine, 2 cycles, flags unchanged.
// RULE_11: 0c kk returns and loads literal into working register, 2 cycles.
// RULE_12: 0f add and 08 subtract literal; one cycle; C DC Z OV N affected.
// RULE_13: 0b and, 09 or, 0a xor literal; one cycle; only Z and N affected.
// RULE_14: 0d multiply and 0e load literal; one cycle; no flags affected.
// RULE_15: ee 00ff kkkk plus f0 kk loads 12-bit literal to pointer ff, 2 cycles.
// RULE_16: 010k loads four bits into low bank select, one cycle.
// RULE_17: 0008..000b table read, 2 cycles, mm gives pointer mode.
// RULE_18: 000c..000f table write, same modes, runs until memory write ends.
// RULE_19: taken test or changed counter costs two cycles, second is a no-op.
// RULE_20: unconsumed second word is a no-op; 1111 word alone is a no-op.
// RULE_21: port read-modify-write from itself takes the operand from pins.
// RULE_22: qualifying write of timer zero clears its prescaler when assigned.
// RULE_23: a low picks access bank, a high bank select; d picks destination.
// RULE_24: 1000 sets, 1001 clears, 0111 toggles file bit; one cycle, no flags.
package decode_pkg;

	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LASTOP = 8'h08;
	localparam logic [7:0] REG_BANK   = 8'h0c;
	localparam logic [7:0] REG_COUNT  = 8'h10;

	// flag positions in the ctrl register and in the affected mask
	localparam int FLAG_C   = 0;
	localparam int FLAG_DC  = 1;
	localparam int FLAG_Z   = 2;
	localparam int FLAG_OV  = 3;
	localparam int FLAG_N   = 4;
	localparam int CTRL_TESTBIT = 5;
	localparam int CTRL_PSA     = 6;

	// status register positions
	localparam int ST_TO   = 0;
	localparam int ST_PD   = 1;
	localparam int ST_GIE  = 2;
	localparam int ST_PEIE = 3;
	localparam int ST_TBL  = 4;
	localparam int ST_PEND = 5;
	localparam int ST_SKIP = 6;

	localparam logic [6:0] CTRL_RESET   = 7'h00;
	localparam logic [1:0] FLAGS_RESET  = 2'h3;
	localparam logic [1:0] IRQEN_RESET  = 2'h0;
	localparam logic [4:0] MASK_ARITH   = 5'h1f;
	localparam logic [4:0] MASK_LOGIC   = 5'h14;
	localparam logic [1:0] CYC_ONE      = 2'h1;
	localparam logic [1:0] CYC_TWO      = 2'h2;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_DECERR  = 2'h3;

	// opcode fields
	localparam logic [3:0] NIB_SKIP_CLR = 4'hb;
	localparam logic [3:0] NIB_SKIP_SET = 4'ha;
	localparam logic [3:0] NIB_BIT_SET  = 4'h8;
	localparam logic [3:0] NIB_BIT_CLR  = 4'h9;
	localparam logic [3:0] NIB_BIT_TOG  = 4'h7;
	localparam logic [3:0] NIB_REL      = 4'hd;
	localparam logic [3:0] NIB_LONG     = 4'he;
	localparam logic [3:0] NIB_SECOND   = 4'hf;
	localparam logic [3:0] NIB_MISC     = 4'h0;

	typedef enum logic [4:0] {
		OP_NOP, OP_OTHER, OP_SKIP_CLR, OP_SKIP_SET, OP_BIT_SET,
		OP_BIT_CLR, OP_BIT_TOG, OP_BRANCH, OP_REL_JUMP, OP_REL_CALL,
		OP_CALL, OP_ABSOLUTE_JUMP_OP, OP_WDT_CLR, OP_POP, OP_PUSH, OP_SW_RESET,
		OP_IRQ_RETURN, OP_RETURN, OP_RET_LIT, OP_ADD, OP_SUB, OP_AND,
		OP_OR, OP_XOR, OP_MUL, OP_LOAD, OP_PTR_LOAD, OP_BANK_LOAD,
		OP_TBL_RD, OP_TBL_WR
	} op_class_t;

	typedef struct packed {
		logic        valid;
		op_class_t   opClass;
		logic [1:0]  cycles;
		logic        taken;
		logic [7:0]  literal;
		logic [10:0] offset;
		logic [19:0] longAddr;
		logic        fastCtx;
		logic [2:0]  bitSel;
		logic [11:0] fileAddr;
		logic        destToFile;
		logic [1:0]  pointerIdx;
		logic [11:0] pointerVal;
		logic [1:0]  tblMode;
		logic [4:0]  flagsAffected;
		logic        pinOperand;
		logic        prescalerClear;
	} decode_t;

endpackage

// ===== src/cpu_instruction_decode.sv
/*
 * instruction decoder for bit, control, literal and table operations
 * with an axi4-lite register slave
 * assumes program memory on mclk presenting one word with valid/ready,
 * and a table write engine reporting completion on mclk
 */
`timescale 1ns/1ps
module cpu_instruction_decode #(
	parameter logic [3:0]  ACCESS_BANK = 4'h0,
	parameter logic [11:0] PORT_LO     = 12'hf80,
	parameter logic [11:0] PORT_HI     = 12'hf8f,
	parameter logic [11:0] TIMER0_ADDR = 12'hfd6
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              reset_n,
	// axi4-lite slave
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// program memory side
	input  wire logic [15:0]       instrWord,
	input  wire logic              instrValid,
	output logic                   instrReady,
	// table write engine
	input  wire logic              tableWriteDone,
	// decoded instruction, one-cycle valid
	output decode_pkg::decode_t    decodeOut
);

	logic                rstMeta_q;
	logic                rst_q;
	logic [6:0]          ctrl_q;
	logic [1:0]          wdtFlags_q;
	logic [1:0]          irqEn_q;
	logic [3:0]          bankSel_q;
	logic                tblBusy_q;
	logic                pending_q;
	logic                pendNop_q;
	logic [15:0]         firstWord_q;
	logic                skip_q;
	logic [15:0]         lastWord_q;
	logic [31:0]         count_q;
	logic                awHeld_q;
	logic                wHeld_q;
	logic [7:0]          awAddr_q;
	logic [31:0]         wData_q;
	logic [3:0]          wStrb_q;
	decode_pkg::decode_t dec;
	logic                firstOfTwo;
	logic                accept;
	logic                stall;
	logic                doWrite;
	logic                ctrlWr;
	logic                statusWr;
	logic                hwSwReset;
	logic                hwIrqRet;
	logic                hwWdt;

	// reset release through two flops
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rstMeta_q <= 1'b0;
			rst_q     <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rst_q     <= rstMeta_q;
		end
	end

	function automatic logic cond_true(input logic [2:0] code,
		input logic [6:0] f);
		logic r;
		unique case (code[2:1])
			2'h0: r = f[decode_pkg::FLAG_Z];
			2'h1: r = f[decode_pkg::FLAG_C];
			2'h2: r = f[decode_pkg::FLAG_OV];
			default: r = f[decode_pkg::FLAG_N];
		endcase
		cond_true = code[0] ? ~r : r;
	endfunction

	// combinational decode of the presented word
	always_comb
	begin
		dec = '0;
		firstOfTwo = 1'b0;
		dec.valid = 1'b1;
		dec.opClass = decode_pkg::OP_OTHER;
		dec.cycles = decode_pkg::CYC_ONE;
		dec.literal = instrWord[7:0];
		dec.bitSel = instrWord[11:9]; // see RULE_01
		dec.fileAddr = instrWord[8] ? {bankSel_q, instrWord[7:0]}
			: {ACCESS_BANK, instrWord[7:0]}; // see RULE_23
		dec.destToFile = instrWord[9]; // see RULE_23
		if (pending_q && instrWord[15:12] == decode_pkg::NIB_SECOND)
		begin
			// second word consumed by the held first word
			dec.cycles = decode_pkg::CYC_TWO;
			dec.taken = 1'b1;
			dec.literal = firstWord_q[7:0];
			dec.fastCtx = firstWord_q[8]; // see RULE_04
			dec.longAddr = {instrWord[11:0], firstWord_q[7:0]};
			dec.pointerIdx = firstWord_q[5:4];
			dec.pointerVal = {firstWord_q[3:0], instrWord[7:0]};
			if (firstWord_q[11:8] == 4'he)
				dec.opClass = decode_pkg::OP_PTR_LOAD; // see RULE_15
			else if (firstWord_q[11:8] == 4'hf)
				dec.opClass = decode_pkg::OP_ABSOLUTE_JUMP_OP; // see RULE_05
			else
				dec.opClass = decode_pkg::OP_CALL; // see RULE_04
		end
		else
		begin
			unique case (instrWord[15:12])
				decode_pkg::NIB_SKIP_CLR, decode_pkg::NIB_SKIP_SET:
				begin
					// see RULE_01
					dec.opClass = instrWord[12] ? decode_pkg::OP_SKIP_CLR
						: decode_pkg::OP_SKIP_SET;
					dec.taken = instrWord[12]
						? ~ctrl_q[decode_pkg::CTRL_TESTBIT]
						: ctrl_q[decode_pkg::CTRL_TESTBIT];
				end
				decode_pkg::NIB_BIT_SET, decode_pkg::NIB_BIT_CLR,
				decode_pkg::NIB_BIT_TOG:
				begin
					// see RULE_24
					dec.opClass = (instrWord[15:12] == decode_pkg::NIB_BIT_SET)
						? decode_pkg::OP_BIT_SET
						: (instrWord[15:12] == decode_pkg::NIB_BIT_CLR)
						? decode_pkg::OP_BIT_CLR : decode_pkg::OP_BIT_TOG;
					dec.destToFile = 1'b1;
					dec.pinOperand = (dec.fileAddr >= PORT_LO)
						&& (dec.fileAddr <= PORT_HI); // see RULE_21
					dec.prescalerClear = (dec.fileAddr == TIMER0_ADDR)
						&& ctrl_q[decode_pkg::CTRL_PSA]; // see RULE_22
				end
				decode_pkg::NIB_REL:
				begin
					// see RULE_03
					dec.opClass = instrWord[11] ? decode_pkg::OP_REL_CALL
						: decode_pkg::OP_REL_JUMP;
					dec.offset = instrWord[10:0];
					dec.taken = 1'b1;
					dec.cycles = decode_pkg::CYC_TWO;
				end
				decode_pkg::NIB_LONG:
				begin
					if (!instrWord[11])
					begin
						// see RULE_02
						dec.opClass = decode_pkg::OP_BRANCH;
						dec.offset = {{3{instrWord[7]}}, instrWord[7:0]};
						dec.taken = cond_true(instrWord[10:8], ctrl_q);
						dec.cycles = dec.taken ? decode_pkg::CYC_TWO
							: decode_pkg::CYC_ONE; // see RULE_19
					end
					else if (instrWord[10:9] == 2'h2
						|| instrWord[10:8] == 3'h7
						|| (instrWord[10:8] == 3'h6 && instrWord[7:6] == 2'h0))
					begin
						// first word held until its second arrives
						dec.valid = 1'b0;
						firstOfTwo = 1'b1;
					end
				end
				decode_pkg::NIB_SECOND:
					dec.opClass = decode_pkg::OP_NOP; // see RULE_20
				decode_pkg::NIB_MISC:
				begin
					unique case (instrWord[11:8])
						4'h0:
						begin
							unique casez (instrWord[7:0])
								8'h00: dec.opClass = decode_pkg::OP_NOP;
								8'h04: dec.opClass = decode_pkg::OP_WDT_CLR;
								8'h05: dec.opClass = decode_pkg::OP_PUSH;
								8'h06: dec.opClass = decode_pkg::OP_POP;
								8'hff: dec.opClass = decode_pkg::OP_SW_RESET;
								8'b0001_000?:
									dec.opClass = decode_pkg::OP_IRQ_RETURN;
								8'b0001_001?:
									dec.opClass = decode_pkg::OP_RETURN;
								8'b0000_10??:
									dec.opClass = decode_pkg::OP_TBL_RD;
								8'b0000_11??:
									dec.opClass = decode_pkg::OP_TBL_WR;
								default: dec.opClass = decode_pkg::OP_OTHER;
							endcase
							dec.fastCtx = instrWord[0]; // see RULE_09
							dec.tblMode = instrWord[1:0]; // see RULE_17
						end
						4'h1: dec.opClass = (instrWord[7:4] == 4'h0)
							? decode_pkg::OP_BANK_LOAD : decode_pkg::OP_OTHER;
						4'hc: dec.opClass = decode_pkg::OP_RET_LIT;
						4'hf: dec.opClass = decode_pkg::OP_ADD;
						4'h8: dec.opClass = decode_pkg::OP_SUB;
						4'hb: dec.opClass = decode_pkg::OP_AND;
						4'h9: dec.opClass = decode_pkg::OP_OR;
						4'ha: dec.opClass = decode_pkg::OP_XOR;
						4'hd: dec.opClass = decode_pkg::OP_MUL;
						4'he: dec.opClass = decode_pkg::OP_LOAD;
						default: dec.opClass = decode_pkg::OP_OTHER;
					endcase
					// see RULE_12 RULE_13 RULE_14
					if (dec.opClass == decode_pkg::OP_ADD
						|| dec.opClass == decode_pkg::OP_SUB)
						dec.flagsAffected = decode_pkg::MASK_ARITH;
					else if (dec.opClass == decode_pkg::OP_AND
						|| dec.opClass == decode_pkg::OP_OR
						|| dec.opClass == decode_pkg::OP_XOR)
						dec.flagsAffected = decode_pkg::MASK_LOGIC;
					// see RULE_09 RULE_10 RULE_11 RULE_17 RULE_18
					if (dec.opClass == decode_pkg::OP_IRQ_RETURN
						|| dec.opClass == decode_pkg::OP_RETURN
						|| dec.opClass == decode_pkg::OP_RET_LIT
						|| dec.opClass == decode_pkg::OP_TBL_RD
						|| dec.opClass == decode_pkg::OP_TBL_WR)
					begin
						dec.cycles = decode_pkg::CYC_TWO;
						dec.taken = 1'b1;
					end
				end
				default: dec.opClass = decode_pkg::OP_OTHER;
			endcase
		end
		// a skipped word runs as a no-op but keeps its length
		if (skip_q || (pending_q && pendNop_q))
		begin
			dec.opClass = decode_pkg::OP_NOP;
			dec.taken = 1'b0;
			dec.flagsAffected = 5'h00;
			dec.pinOperand = 1'b0;
			dec.prescalerClear = 1'b0;
		end
	end

	assign accept = instrValid && instrReady;
	// one-word instructions of two cycles insert a no-op cycle
	assign stall = dec.valid && dec.cycles == decode_pkg::CYC_TWO
		&& !pending_q; // see RULE_19
	assign hwSwReset = accept && dec.valid
		&& dec.opClass == decode_pkg::OP_SW_RESET;
	assign hwIrqRet = accept && dec.valid
		&& dec.opClass == decode_pkg::OP_IRQ_RETURN;
	assign hwWdt = accept && dec.valid
		&& dec.opClass == decode_pkg::OP_WDT_CLR;

	// sequencing of fetches
	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			instrReady  <= 1'b0;
			pending_q   <= 1'b0;
			pendNop_q   <= 1'b0;
			firstWord_q <= 16'h0000;
			skip_q      <= 1'b0;
			decodeOut   <= '0;
		end
		else
		begin
			decodeOut.valid <= 1'b0;
			instrReady <= !(tblBusy_q && !tableWriteDone);
			if (accept)
			begin
				decodeOut <= dec;
				if (stall || (dec.valid && dec.opClass == decode_pkg::OP_TBL_WR))
					instrReady <= 1'b0;
				pending_q <= firstOfTwo;
				pendNop_q <= firstOfTwo && skip_q; // see RULE_20
				if (firstOfTwo)
					firstWord_q <= instrWord;
				// a skip covers the next word and, if two-word, its second
				skip_q <= dec.valid && dec.taken
					&& (dec.opClass == decode_pkg::OP_SKIP_CLR
					|| dec.opClass == decode_pkg::OP_SKIP_SET); // see RULE_01
				if (dec.opClass == decode_pkg::OP_SW_RESET && dec.valid)
				begin
					pending_q <= 1'b0;
					skip_q    <= 1'b0; // see RULE_08
				end
			end
		end
	end

	// table write holds fetch until the memory write ends
	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
			tblBusy_q <= 1'b0;
		else if (accept && dec.valid && dec.opClass == decode_pkg::OP_TBL_WR)
			tblBusy_q <= 1'b1; // see RULE_18
		else if (tableWriteDone)
			tblBusy_q <= 1'b0;
	end

	// bank select, instruction history
	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			bankSel_q  <= 4'h0;
			lastWord_q <= 16'h0000;
			count_q    <= 32'h0000_0000;
		end
		else if (hwSwReset)
			bankSel_q <= 4'h0; // see RULE_08
		else if (accept)
		begin
			lastWord_q <= instrWord;
			if (dec.valid)
				count_q <= count_q + 32'h0000_0001;
			if (dec.valid && dec.opClass == decode_pkg::OP_BANK_LOAD)
				bankSel_q <= instrWord[3:0]; // see RULE_16
		end
	end

	// status flags; hardware events win over software writes
	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			wdtFlags_q <= decode_pkg::FLAGS_RESET;
			irqEn_q    <= decode_pkg::IRQEN_RESET;
			ctrl_q     <= decode_pkg::CTRL_RESET;
		end
		else if (hwSwReset)
		begin
			wdtFlags_q <= decode_pkg::FLAGS_RESET;
			irqEn_q    <= decode_pkg::IRQEN_RESET;
			ctrl_q     <= decode_pkg::CTRL_RESET; // see RULE_08
		end
		else
		begin
			if (ctrlWr)
				ctrl_q <= wData_q[6:0];
			if (hwWdt)
				wdtFlags_q <= decode_pkg::FLAGS_RESET; // see RULE_06
			if (hwIrqRet)
				irqEn_q <= 2'h3; // see RULE_09
			else if (statusWr)
				irqEn_q <= wData_q[decode_pkg::ST_PEIE:decode_pkg::ST_GIE];
		end
	end

	// axi4-lite write channel
	assign doWrite  = awHeld_q && wHeld_q && !bvalid;
	assign ctrlWr   = doWrite && wStrb_q[0] && awAddr_q == decode_pkg::REG_CTRL;
	assign statusWr = doWrite && wStrb_q[0]
		&& awAddr_q == decode_pkg::REG_STATUS;

	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			awready  <= 1'b1;
			wready   <= 1'b1;
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q  <= 32'h0000_0000;
			wStrb_q  <= 4'h0;
			bvalid   <= 1'b0;
			bresp    <= decode_pkg::RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awHeld_q <= 1'b1;
				awready  <= 1'b0;
				awAddr_q <= {awaddr[7:2], 2'b00};
			end
			if (wvalid && wready)
			begin
				wHeld_q <= 1'b1;
				wready  <= 1'b0;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (doWrite)
			begin
				awHeld_q <= 1'b0;
				wHeld_q  <= 1'b0;
				bvalid   <= 1'b1;
				bresp    <= (awAddr_q <= decode_pkg::REG_COUNT)
					? decode_pkg::RESP_OKAY : decode_pkg::RESP_DECERR;
			end
			if (bvalid && bready)
			begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// axi4-lite read channel
	always_ff @(posedge mclk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= decode_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= decode_pkg::RESP_OKAY;
			rdata   <= 32'h0000_0000;
			unique case ({araddr[7:2], 2'b00})
				decode_pkg::REG_CTRL:   rdata <= {25'h0, ctrl_q};
				decode_pkg::REG_STATUS: rdata <= {25'h0, skip_q, pending_q,
					tblBusy_q, irqEn_q, wdtFlags_q};
				decode_pkg::REG_LASTOP: rdata <= {lastWord_q, 5'h00,
					decodeOut.taken, decodeOut.cycles, 3'h0,
					decodeOut.opClass};
				decode_pkg::REG_BANK:   rdata <= {28'h0, bankSel_q};
				decode_pkg::REG_COUNT:  rdata <= count_q;
				default:                rresp <= decode_pkg::RESP_DECERR;
			endcase
		end
		else if (rvalid && rready)
		begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

endmodule

// ===== test/decode_props.sv
/*
 * port assertions for the instruction decoder
 * assumes one mclk domain
 */
`timescale 1ns/1ps
module decode_props (
	// clock and reset
	input wire logic                mclk,
	input wire logic                reset_n,
	// register bus handshakes
	input wire logic                awvalid,
	input wire logic                awready,
	input wire logic                wvalid,
	input wire logic                wready,
	input wire logic                bvalid,
	input wire logic                arvalid,
	input wire logic                arready,
	input wire logic                rvalid,
	// instruction side
	input wire logic                instrReady,
	input wire logic                tableWriteDone,
	input wire decode_pkg::decode_t decodeOut
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	wire       v  = decodeOut.valid;
	wire [4:0] op = decodeOut.opClass;
	wire [4:0] fl = decodeOut.flagsAffected;
	wire [1:0] cy = decodeOut.cycles;
	arith_flags_a: assert property (
		v && op inside {decode_pkg::OP_ADD, decode_pkg::OP_SUB}
		|-> fl == 5'h1f && cy == 2'h1)
		else $error("arith mask or cycles");
	logic_flags_a: assert property (
		v && op inside {decode_pkg::OP_AND, decode_pkg::OP_OR,
		decode_pkg::OP_XOR} |-> fl == 5'h14 && cy == 2'h1)
		else $error("logic mask or cycles");
	quiet_flags_a: assert property (
		v && op inside {decode_pkg::OP_MUL, decode_pkg::OP_LOAD,
		decode_pkg::OP_POP, decode_pkg::OP_PUSH, decode_pkg::OP_RETURN,
		decode_pkg::OP_BIT_SET, decode_pkg::OP_BIT_CLR,
		decode_pkg::OP_BIT_TOG} |-> fl == 5'h0)
		else $error("flag mask not empty");
	single_cycle_a: assert property (
		v && op inside {decode_pkg::OP_WDT_CLR, decode_pkg::OP_SW_RESET,
		decode_pkg::OP_BANK_LOAD, decode_pkg::OP_MUL, decode_pkg::OP_LOAD,
		decode_pkg::OP_BIT_SET, decode_pkg::OP_BIT_TOG} |-> cy == 2'h1)
		else $error("not one cycle");
	two_cycle_a: assert property (
		v && op inside {decode_pkg::OP_REL_JUMP, decode_pkg::OP_REL_CALL,
		decode_pkg::OP_IRQ_RETURN, decode_pkg::OP_RETURN,
		decode_pkg::OP_RET_LIT, decode_pkg::OP_TBL_RD,
		decode_pkg::OP_TBL_WR} |-> cy == 2'h2 && !instrReady)
		else $error("two cycle without stall");
	long_cycle_a: assert property (
		v && op inside {decode_pkg::OP_CALL, decode_pkg::OP_ABSOLUTE_JUMP_OP,
		decode_pkg::OP_PTR_LOAD} |-> cy == 2'h2)
		else $error("two word not two cycles");
	branch_cycle_a: assert property (
		v && op == decode_pkg::OP_BRANCH
		|-> cy == (decodeOut.taken ? 2'h2 : 2'h1)
		&& instrReady == !decodeOut.taken)
		else $error("branch cycles wrong");
	table_busy_a: assert property (
		v && op == decode_pkg::OP_TBL_WR && !tableWriteDone
		|=> !instrReady)
		else $error("table write released early");
	write_resp_a: assert property (
		awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
		else $error("write response late");
	read_resp_a: assert property (
		arvalid && arready |=> rvalid && !arready)
		else $error("read response late");
endmodule
bind cpu_instruction_decode decode_props i_props (
	.mclk, .reset_n, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.arvalid, .arready, .rvalid, .instrReady, .tableWriteDone, .decodeOut
);

// ===== test/prog_mem.sv
/*
 * program memory model offering one word at a time
 * assumes calls just after mclk rises
 */
`timescale 1ns/1ps
module prog_mem (
	// clock
	input  wire logic   mclk,
	// instruction port
	input  wire logic   instrReady,
	output logic [15:0] instrWord,
	output logic        instrValid
);
	logic [15:0] lastWord = 16'h0000;
	initial
	begin
		instrWord = 16'hffff;
		instrValid = 1'b0;
	end
	// word and valid stand until ready is sampled high
	task automatic fetch(input logic [15:0] w);
		int n = 0;
		lastWord = w;
		instrWord <= w;
		instrValid <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end while (instrReady !== 1'b1 && n < 200);
	endtask
	// released bus shows the inverse of the last word
	task automatic rest(input int k);
		instrValid <= 1'b0;
		instrWord <= ~lastWord;
		repeat (k) @(posedge mclk);
	endtask
endmodule

// ===== test/tb.sv
/*
 * bench for the instruction decoder
 * assumes prog_mem as the word source
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	fails++; $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
	end end
module tb;
	logic                  mclk = 1'b0;
	logic                  reset_n;
	logic [7:0]            awaddr, araddr;
	logic [31:0]           wdata, rdata;
	logic [3:0]            wstrb;
	logic                  awvalid, wvalid, bready, arvalid, rready;
	logic                  awready, wready, bvalid, arready, rvalid;
	logic                  tableWriteDone, instrReady, instrValid;
	logic [1:0]            bresp, rresp, rr, cy;
	logic [15:0]           instrWord, w;
	logic [7:0]            tk;
	logic [4:0]            f;
	decode_pkg::decode_t   decodeOut, d;
	decode_pkg::decode_t   q[$];
	decode_pkg::op_class_t o;
	int                    fails = 0;
	int                    comparisons = 0;
	logic [15:0] lits[7] = '{16'h0f15, 16'h0826, 16'h0b37, 16'h0948,
		16'h0a59, 16'h0d6a, 16'h0e7b};
	cpu_instruction_decode #(.ACCESS_BANK(4'hf)) i_dut (
		.mclk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .instrWord,
		.instrValid, .instrReady, .tableWriteDone, .decodeOut
	);
	prog_mem i_mem (.mclk, .instrReady, .instrWord, .instrValid);
	always #5 mclk = ~mclk;
	always @(posedge mclk)
		if (decodeOut.valid === 1'b1)
			q.push_back(decodeOut);
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s = 4'hf);
		int n = 0;
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid && n < 99);
		rr = bresp;
		bready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		int n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid && n < 99);
		rr = rresp;
		rready <= 1'b0;
		`CHK(nm, e, rdata)
		@(posedge mclk);
	endtask
	task automatic take(input decode_pkg::op_class_t e, input logic [1:0] c);
		d = q.size() ? q.pop_front() : '1;
		`CHK("opClass", e, d.opClass)
		if (c != 2'h0)
			`CHK("cycles", c, d.cycles)
	endtask
	task automatic step(input logic [15:0] x,
		input decode_pkg::op_class_t e, input logic [1:0] c);
		i_mem.fetch(x);
		i_mem.rest(2);
		take(e, c);
	endtask
	task automatic close_out();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		reset_n = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready, tableWriteDone} = '0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(8'h00, 32'h0, "ctrl");
		rd(8'h04, 32'h3, "status");
		rd(8'h14, 32'h0, "unmapped");
		`CHK("rresp", 2'h3, rr)
		wr(8'h14, 32'hff);
		`CHK("bresp", 2'h3, rr)
		wr(8'h00, 32'h7f);
		rd(8'h00, 32'h7f, "ctrl");
		wr(8'h00, 32'h11, 4'he);
		rd(8'h00, 32'h7f, "ctrl");
		$display("registers done");
		// back to back words, no gap
		for (int i = 0; i < 7; i++)
			i_mem.fetch(lits[i]);
		i_mem.rest(2);
		for (int i = 0; i < 7; i++)
		begin
			o = decode_pkg::op_class_t'(decode_pkg::OP_ADD + i);
			f = i < 2 ? 5'h1f : (i < 5 ? 5'h14 : 5'h00);
			take(o, 2'h1);
			`CHK("flags", f, d.flagsAffected)
			`CHK("literal", lits[i][7:0], d.literal)
		end
		$display("literal done");
		for (int j = 0; j < 2; j++)
		begin
			wr(8'h00, j ? 32'h1b : 32'h04);
			tk = j ? 8'h56 : 8'ha9;
			for (int c = 0; c < 8; c++)
			begin
				w = {5'h1c, 3'(c), 8'hfe};
				cy = tk[c] ? 2'h2 : 2'h1;
				step(w, decode_pkg::OP_BRANCH, cy);
				`CHK("taken", tk[c], d.taken)
				`CHK("offset", 11'h7fe, d.offset)
			end
		end
		step(16'hd005, decode_pkg::OP_REL_JUMP, 2'h2);
		`CHK("offset", 11'h005, d.offset)
		step(16'hdc05, decode_pkg::OP_REL_CALL, 2'h2);
		`CHK("offset", 11'h405, d.offset)
		$display("branch done");
		i_mem.fetch(16'hed12);
		step(16'hf345, decode_pkg::OP_CALL, 2'h2);
		`CHK("call", 21'h134512, {d.fastCtx, d.longAddr})
		i_mem.fetch(16'hef12);
		step(16'hf345, decode_pkg::OP_ABSOLUTE_JUMP_OP, 2'h2);
		`CHK("jump", 20'h34512, d.longAddr)
		i_mem.fetch(16'hee2a);
		step(16'hf0bc, decode_pkg::OP_PTR_LOAD, 2'h2);
		`CHK("pointer", 14'h2abc, {d.pointerIdx, d.pointerVal})
		step(16'hf123, decode_pkg::OP_NOP, 2'h1);
		$display("two word done");
		step(16'h0107, decode_pkg::OP_BANK_LOAD, 2'h1);
		rd(8'h0c, 32'h7, "bank");
		step(16'h0011, decode_pkg::OP_IRQ_RETURN, 2'h2);
		`CHK("fastCtx", 1'b1, d.fastCtx)
		rd(8'h04, 32'hf, "status");
		step(16'h0012, decode_pkg::OP_RETURN, 2'h2);
		step(16'h0c7e, decode_pkg::OP_RET_LIT, 2'h2);
		`CHK("literal", 8'h7e, d.literal)
		step(16'h0006, decode_pkg::OP_POP, 2'h1);
		step(16'h0005, decode_pkg::OP_PUSH, 2'h1);
		step(16'h0004, decode_pkg::OP_WDT_CLR, 2'h1);
		step(16'h00ff, decode_pkg::OP_SW_RESET, 2'h1);
		rd(8'h04, 32'h3, "status");
		rd(8'h0c, 32'h0, "bank");
		rd(8'h00, 32'h0, "ctrl");
		$display("control done");
		for (int m = 0; m < 8; m++)
		begin
			o = m < 4 ? decode_pkg::OP_TBL_RD : decode_pkg::OP_TBL_WR;
			step(16'(8 + m), o, 2'h2);
			`CHK("tblMode", 2'(m), d.tblMode)
			if (m >= 4)
			begin
				`CHK("ready", 1'b0, instrReady)
				tableWriteDone <= 1'b1;
				@(posedge mclk);
				tableWriteDone <= 1'b0;
				i_mem.rest(2);
			end
		end
		$display("table done");
		wr(8'h00, 32'h40);
		step(16'h0105, decode_pkg::OP_BANK_LOAD, 2'h1);
		step(16'hb123, decode_pkg::OP_SKIP_CLR, 2'h0);
		step(16'h0e55, decode_pkg::OP_NOP, 2'h0);
		step(16'ha123, decode_pkg::OP_SKIP_SET, 2'h0);
		step(16'h0e55, decode_pkg::OP_LOAD, 2'h1);
		step(16'h9b34, decode_pkg::OP_BIT_CLR, 2'h1);
		`CHK("file", 15'h5534, {d.bitSel, d.fileAddr})
		step(16'h7a85, decode_pkg::OP_BIT_TOG, 2'h1);
		`CHK("file", 16'hdf85, {d.pinOperand, d.bitSel, d.fileAddr})
		step(16'h80d6, decode_pkg::OP_BIT_SET, 2'h1);
		`CHK("prescale", 1'b1, d.prescalerClear)
		wr(8'h00, 32'h60);
		step(16'ha123, decode_pkg::OP_SKIP_SET, 2'h0);
		i_mem.fetch(16'hef00);
		step(16'hf000, decode_pkg::OP_NOP, 2'h0);
		$display("bit done");
		close_out();
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		fails++;
		close_out();
	end
endmodule
